// ===== lgp_pin_select.sv
// How it works
// [RQ1] A pin whose indicator enable bit is set drives its indicator output.
// [RQ2] A pin whose indicator enable bit is clear acts as general purpose I/O.
// [RQ3] The indicator function field picks push-pull or open-drain/open-source driving of indicator pins.
// [RQ4] In open style each indicator's active level follows the strap sampled on that pin at reset.
// [RQ5] In general I/O use each pin is a push-pull output, an open-drain output or an input, as software sets.
// [RQ6] A low memory-size strap selects the small serial memory class, 1K to 16K bits.
// [RQ7] A high memory-size strap selects the large serial memory class, 32K to 512K bits.
// [RQ8] The port-1 internal PHY strap is handed on to the port 0/1 mode logic.
// [RQ9] The management mode comes straight from the host interface strap 0.
// [RQ10] Straps are latched on power-on reset and again when the reset pin is released.
// [RQ11] Strap values change only during reset, so indicator polarity is steady in operation; the latch here takes its last sample one edge after reset release.
// [RQ12] Indicator logic has no effect on a pin while it is in general I/O use.
`timescale 1ns/1ps
`default_nettype none
`include "lgp_regs.svh"

module lgp_pin_select (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  rstPinN,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // indicator sources, same clock
  input  wire logic [2:0]            indicatorOn,
  // shared pins: bit 2..0 = indicator_out_n / general_io_n
  input  wire logic [2:0]            padIn,
  output lgp_pkg::lgp_pad_drive_t    padDrive,
  // strap-derived hard settings
  output lgp_pkg::lgp_strap_t        strapCfg
);

  function automatic logic isOpenStyle(input logic [2:0] fun);
    logic [7:0] mask;
    mask        = `LGP_FUN_OPEN_MASK;
    isOpenStyle = mask[fun];
  endfunction

  function automatic lgp_pkg::lgp_gio_mode_t gioMode(input logic dir, input logic od);
    if (!dir) begin
      gioMode = lgp_pkg::LGP_DIR_IN;
    end else if (od) begin
      gioMode = lgp_pkg::LGP_DIR_OPENDRAIN;
    end else begin
      gioMode = lgp_pkg::LGP_DIR_PUSHPULL;
    end
  endfunction

  // ---- synchronisers and straps ----
  logic [2:0] padSync;
  logic       rstPinNSync;
  logic       pinRst;
  logic       coreRst;
  logic [2:0] openPol;

  lgp_sync2 #(.W(3), .RSTVAL(`LGP_PAD_SYNC_RST)) u_padSync (
    .clk   (clk),
    .rst   (rst),
    .async (padIn),
    .sync  (padSync)
  );

  // reset pin held asserted until two clean samples
  lgp_sync2 #(.W(1), .RSTVAL(3'h0)) u_rstSync (
    .clk   (clk),
    .rst   (rst),
    .async (rstPinN),
    .sync  (rstPinNSync)
  );

  assign pinRst  = ~rstPinNSync;
  assign coreRst = rst | pinRst;

  lgp_strap_latch u_strap (
    .clk     (clk),
    .rst     (rst),
    .pinRst  (pinRst),
    .padSync (padSync),
    .straps  (strapCfg),
    .openPol (openPol)
  );

  // ---- register state ----
  logic [2:0]  indEn_reg,   indEn_next;
  logic [2:0]  indFun_reg,  indFun_next;
  logic [2:0]  gioOd_reg,   gioOd_next;
  logic [2:0]  gioData_reg, gioData_next;
  logic [2:0]  gioDir_reg,  gioDir_next;
  logic        wrPend_reg,  wrPend_next;
  logic [31:0] wrAddr_reg,  wrAddr_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic        addrPhase;

  assign addrPhase = hsel && htrans[1] && hready;

  // write lands in data phase; read mux sees those next values so a read
  // right behind a write returns the new contents
  always_comb begin
    indEn_next   = indEn_reg;
    indFun_next  = indFun_reg;
    gioOd_next   = gioOd_reg;
    gioData_next = gioData_reg;
    gioDir_next  = gioDir_reg;
    if (wrPend_reg) begin
      unique case (wrAddr_reg)
        `LGP_ADDR_IND_CFG: begin
          indEn_next  = hwdata[`LGP_IND_EN_LSB +: 3];
          indFun_next = hwdata[`LGP_IND_FUN_LSB +: 3];
        end
        `LGP_ADDR_GIO_CFG: begin
          gioOd_next = hwdata[`LGP_GIO_OD_LSB +: 3];
        end
        `LGP_ADDR_GIO_DATADIR: begin
          gioData_next = hwdata[`LGP_GIO_DATA_LSB +: 3];
          gioDir_next  = hwdata[`LGP_GIO_DIR_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
    wrPend_next = addrPhase && hwrite;
    wrAddr_next = haddr;
    rdata_next  = 32'h0000_0000;
    if (addrPhase && !hwrite) begin
      unique case (haddr)
        `LGP_ADDR_IND_CFG: begin
          rdata_next[`LGP_IND_EN_LSB +: 3]  = indEn_next;
          rdata_next[`LGP_IND_FUN_LSB +: 3] = indFun_next;
        end
        `LGP_ADDR_GIO_CFG: begin
          rdata_next[`LGP_GIO_OD_LSB +: 3] = gioOd_next;
        end
        `LGP_ADDR_GIO_DATADIR: begin
          // input pins show the pad level, output pins the written data
          rdata_next[`LGP_GIO_DATA_LSB +: 3] = (gioDir_next & gioData_next) | (~gioDir_next & padSync); // RQ5
          rdata_next[`LGP_GIO_DIR_LSB +: 3]  = gioDir_next;
        end
        `LGP_ADDR_STRAP_STAT: begin
          rdata_next[`LGP_STRAP_MEM_BIT]  = strapCfg.memSizeLarge; // RQ6 RQ7
          rdata_next[`LGP_STRAP_P1_BIT]   = strapCfg.port1IntPhy;  // RQ8
          rdata_next[`LGP_STRAP_MGMT_BIT] = strapCfg.mgmtMode;     // RQ9
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (coreRst) begin
      indEn_reg   <= `LGP_IND_EN_RST;
      indFun_reg  <= `LGP_IND_FUN_RST;
      gioOd_reg   <= `LGP_GIO_OD_RST;
      gioData_reg <= `LGP_GIO_DATA_RST;
      gioDir_reg  <= `LGP_GIO_DIR_RST;
      wrPend_reg  <= 1'b0;
      wrAddr_reg  <= 32'h0000_0000;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      indEn_reg   <= indEn_next;
      indFun_reg  <= indFun_next;
      gioOd_reg   <= gioOd_next;
      gioData_reg <= gioData_next;
      gioDir_reg  <= gioDir_next;
      wrPend_reg  <= wrPend_next;
      wrAddr_reg  <= wrAddr_next;
      rdata_reg   <= rdata_next;
    end
  end

  // zero wait states, always OKAY
  logic hreadyout_reg;
  always_ff @(posedge clk) begin
    hreadyout_reg <= 1'b1;
  end

  assign hrdata    = rdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = 1'b0;

  // ---- pin mux ----
  lgp_pkg::lgp_pad_drive_t drive_reg;
  lgp_pkg::lgp_pad_drive_t drive_next;

  always_comb begin
    drive_next = '0;
    for (int i = 0; i < 3; i++) begin
      if (indEn_reg[i]) begin // RQ1
        if (isOpenStyle(indFun_reg)) begin // RQ3
          // strap pulled high means the board wires the lamp active low
          drive_next.oe[i]  = indicatorOn[i];
          drive_next.out[i] = ~openPol[i]; // RQ4
        end else begin
          drive_next.oe[i]  = 1'b1;
          drive_next.out[i] = indicatorOn[i];
        end
      end else begin // RQ2 RQ12
        unique case (gioMode(gioDir_reg[i], gioOd_reg[i])) // RQ5
          lgp_pkg::LGP_DIR_IN: begin
            drive_next.oe[i]  = 1'b0;
            drive_next.out[i] = 1'b0;
          end
          lgp_pkg::LGP_DIR_PUSHPULL: begin
            drive_next.oe[i]  = 1'b1;
            drive_next.out[i] = gioData_reg[i];
          end
          lgp_pkg::LGP_DIR_OPENDRAIN: begin
            drive_next.oe[i]  = ~gioData_reg[i];
            drive_next.out[i] = 1'b0;
          end
          default: begin
            drive_next.oe[i]  = 1'b0;
            drive_next.out[i] = 1'b0;
          end
        endcase
      end
    end
  end

  // pins released during any reset so straps read their resistors
  always_ff @(posedge clk) begin
    if (coreRst) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign padDrive = drive_reg;

  // ---- checks ----
  a_ind_pushpull_route: assert property (@(posedge clk) disable iff (coreRst)
    $past(!coreRst) && !isOpenStyle($past(indFun_reg))
    |-> ((padDrive.oe & $past(indEn_reg)) == $past(indEn_reg))
        && (((padDrive.out ^ $past(indicatorOn)) & $past(indEn_reg)) == 3'h0))
    else $error("push-pull indicator not routed"); // RQ1 RQ3
  a_ind_open_polarity: assert property (@(posedge clk) disable iff (coreRst)
    $past(!coreRst) && isOpenStyle($past(indFun_reg))
    |-> (((padDrive.oe ^ $past(indicatorOn)) & $past(indEn_reg)) == 3'h0)
        && (((padDrive.out ^ ~openPol) & $past(indEn_reg & indicatorOn)) == 3'h0))
    else $error("open indicator level wrong"); // RQ3 RQ4
  a_gio_input_quiet: assert property (@(posedge clk) disable iff (coreRst)
    $past(!coreRst) |-> (padDrive.oe & ~$past(indEn_reg) & ~$past(gioDir_reg)) == 3'h0)
    else $error("input pin driven"); // RQ2 RQ5
  a_gio_od_nohigh: assert property (@(posedge clk) disable iff (coreRst)
    $past(!coreRst) |-> (padDrive.oe & padDrive.out & ~$past(indEn_reg) & $past(gioOd_reg)) == 3'h0)
    else $error("open-drain pin driven high"); // RQ5
  a_gio_ignores_ind: assert property (@(posedge clk) disable iff (coreRst)
    $past(!coreRst, 2) && $stable(indEn_reg) && $stable(gioDir_reg) && $stable(gioData_reg)
    && $stable(gioOd_reg) ##1 1'b1
    |-> ((padDrive ^ $past(padDrive)) & {~$past(indEn_reg, 2), ~$past(indEn_reg, 2)}) == 6'h00)
    else $error("indicator leaked into general io"); // RQ12
  a_strap_status_read: assert property (@(posedge clk) disable iff (coreRst)
    addrPhase && !hwrite && haddr == `LGP_ADDR_STRAP_STAT
    |=> hrdata[2:0] == {strapCfg.mgmtMode, strapCfg.port1IntPhy, strapCfg.memSizeLarge})
    else $error("strap status read wrong"); // RQ6 RQ7 RQ8 RQ9
  a_pad_reset_release: assert property (@(posedge clk) coreRst |=> padDrive.oe == 3'h0)
    else $error("pin driven during reset"); // RQ10
  a_bus_zero_wait: assert property (@(posedge clk) disable iff (rst)
    $past(!rst) |-> hreadyout && !hresp)
    else $error("bus stalled or errored"); // RQ5

endmodule // lgp_pin_select

`default_nettype wire

// ===== lgp_regs.svh
`ifndef LGP_REGS_SVH
`define LGP_REGS_SVH

// register byte addresses
`define LGP_ADDR_IND_CFG     32'h0000_0000
`define LGP_ADDR_GIO_CFG     32'h0000_0004
`define LGP_ADDR_GIO_DATADIR 32'h0000_0008
`define LGP_ADDR_STRAP_STAT  32'h0000_000c

// indicator_config_reg fields
`define LGP_IND_EN_LSB       0
`define LGP_IND_FUN_LSB      8
// general_io_config_reg fields: 1 = open-drain output
`define LGP_GIO_OD_LSB       0
// general_io data/direction fields: direction 1 = output
`define LGP_GIO_DATA_LSB     0
`define LGP_GIO_DIR_LSB      8
// strap status fields
`define LGP_STRAP_MEM_BIT    0
`define LGP_STRAP_P1_BIT     1
`define LGP_STRAP_MGMT_BIT   2

// indicator function codes that select open-drain/open-source style
`define LGP_FUN_OPEN_MASK    8'hf0

// reset values
`define LGP_IND_EN_RST       3'h0
`define LGP_IND_FUN_RST      3'h0
`define LGP_GIO_OD_RST       3'h0
`define LGP_GIO_DATA_RST     3'h0
`define LGP_GIO_DIR_RST      3'h0
`define LGP_PAD_SYNC_RST     3'h7

`endif

// ===== lgp_pkg.sv
package lgp_pkg;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } lgp_pad_drive_t;

  typedef struct packed {
    logic memSizeLarge;
    logic port1IntPhy;
    logic mgmtMode;
  } lgp_strap_t;

  typedef enum logic [1:0] {
    LGP_DIR_IN,
    LGP_DIR_PUSHPULL,
    LGP_DIR_OPENDRAIN
  } lgp_gio_mode_t;

endpackage

// ===== lgp_sync2.sv
`timescale 1ns/1ps
`default_nettype none
`include "lgp_regs.svh"

module lgp_sync2 #(
  parameter int         W      = 1,
  parameter logic [2:0] RSTVAL = `LGP_PAD_SYNC_RST
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] sync
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage1_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    stage1_next = async;
    sync_next   = stage1_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= RSTVAL[W-1:0];
      sync_reg   <= RSTVAL[W-1:0];
    end else begin
      stage1_reg <= stage1_next;
      sync_reg   <= sync_next;
    end
  end

  assign sync = sync_reg;

endmodule // lgp_sync2

`default_nettype wire

// ===== lgp_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none
`include "lgp_regs.svh"

module lgp_strap_latch (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              pinRst,
  input  wire logic [2:0]        padSync,
  output lgp_pkg::lgp_strap_t    straps,
  output logic      [2:0]        openPol
);

  lgp_pkg::lgp_strap_t strap_reg;
  lgp_pkg::lgp_strap_t strap_next;
  logic                rstSeen_reg;
  logic                rstSeen_next;

  // follow the undriven pads through reset, freeze one edge after release:
  // the pad synchroniser leaves reset together with the reset pin synchroniser and needs that
  // extra edge before it shows the pad levels instead of its reset value
  always_comb begin
    strap_next   = strap_reg;
    rstSeen_next = rst || pinRst;
    if (rst || pinRst || rstSeen_reg) begin // RQ10
      strap_next.memSizeLarge = padSync[2]; // RQ6 RQ7
      strap_next.port1IntPhy  = padSync[1]; // RQ8
      strap_next.mgmtMode     = padSync[0]; // RQ9
    end
  end

  always_ff @(posedge clk) begin
    strap_reg   <= strap_next; // RQ11
    rstSeen_reg <= rstSeen_next;
  end

  assign straps  = strap_reg;
  assign openPol = {strap_reg.memSizeLarge, strap_reg.port1IntPhy, strap_reg.mgmtMode}; // RQ4

  a_strap_frozen_run: assert property (@(posedge clk) !rst && !pinRst && !rstSeen_reg
    && !$past(rst || pinRst || rstSeen_reg)
    |-> $stable(strap_reg)) else $error("strap changed outside reset"); // RQ11
  a_strap_reset_take: assert property (@(posedge clk) (rst || pinRst)
    |=> strap_reg == {$past(padSync[2]), $past(padSync[1]), $past(padSync[0])})
    else $error("strap not sampled during reset"); // RQ10

endmodule // lgp_strap_latch

`default_nettype wire

// ===== lgp_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

module lgp_pad_model (
  input  wire logic [2:0]              strapLevel,
  input  wire lgp_pkg::lgp_pad_drive_t padDrive,
  output logic      [2:0]              padIn
);
  // a released pad settles to its board resistor, never to the last driven value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      padIn[i] = padDrive.oe[i] ? padDrive.out[i] : strapLevel[i];
    end
  end
endmodule // lgp_pad_model

`default_nettype wire

// ===== led_gpio_pin_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lgp_regs.svh"

module led_gpio_pin_select_tb_top;
  logic                    clk         = 1'b0;
  logic                    rst         = 1'b1;
  logic                    rstPinN     = 1'b1;
  logic                    hsel        = 1'b0;
  logic [31:0]             haddr       = 32'h0;
  logic [1:0]              htrans      = 2'h0;
  logic                    hwrite      = 1'b0;
  logic [31:0]             hwdata      = 32'h0;
  logic [2:0]              indicatorOn = 3'h0;
  logic [2:0]              strapLevel  = 3'h5;
  logic [31:0]             hrdata;
  logic                    hreadyout;
  logic                    hresp;
  logic                    hready;
  logic [2:0]              padIn;
  lgp_pkg::lgp_pad_drive_t padDrive;
  lgp_pkg::lgp_strap_t     strapCfg;
  int                      num_errors  = 0;
  int                      compares    = 0;

  assign hready = hreadyout;

  always #5 clk = ~clk;

  lgp_pin_select DUT (.clk(clk), .rst(rst), .rstPinN(rstPinN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .indicatorOn(indicatorOn), .padIn(padIn), .padDrive(padDrive), .strapCfg(strapCfg));

  lgp_pad_model PADS (.strapLevel(strapLevel), .padDrive(padDrive), .padIn(padIn));

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [2:0] got, input logic [2:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // one single word transfer; waits on hready in both phases
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    chk_pins({2'b00, hresp}, 3'h0, "bus response");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk_word(q, exp, what);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #300us;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(`LGP_ADDR_STRAP_STAT, 32'h5, "strap status");
    chk_pins(strapCfg, 3'h5, "strap outputs");
    rd_chk(`LGP_ADDR_IND_CFG, 32'h0, "indicator cfg reset");
    rd_chk(`LGP_ADDR_GIO_CFG, 32'h0, "io cfg reset");
    rd_chk(`LGP_ADDR_GIO_DATADIR, 32'h5, "pad levels as inputs");
    rd_chk(32'h0000_0010, 32'h0, "unmapped read");
    chk_pins(padDrive.oe, 3'h0, "inputs after reset");
    $display("test reset done");

    @(posedge clk);
    indicatorOn <= 3'h7;
    wr(`LGP_ADDR_GIO_DATADIR, 32'h0000_0703);
    chk_pins(padDrive.oe, 3'h7, "push-pull enables");
    chk_pins(padDrive.out, 3'h3, "push-pull levels");
    wr(`LGP_ADDR_GIO_CFG, 32'h7);
    chk_pins(padDrive.oe, 3'h4, "open-drain enables");
    chk_pins({padDrive.out[2], 2'b00}, 3'h0, "open-drain low");
    rd_chk(`LGP_ADDR_GIO_DATADIR, 32'h0000_0703, "data readback");
    $display("test general io done");

    @(posedge clk);
    indicatorOn <= 3'h6;
    // codes 0..3 push-pull, 4..7 open style with strap-set polarity
    for (int f = 0; f < 8; f++) begin
      wr(`LGP_ADDR_IND_CFG, (32'(f) << 8) | 32'h7);
      if (f < 4) begin
        chk_pins(padDrive.oe, 3'h7, "push-pull indicator oe");
        chk_pins(padDrive.out, 3'h6, "push-pull indicator out");
      end else begin
        chk_pins(padDrive.oe, 3'h6, "open indicator oe");
        chk_pins(padDrive.out & 3'h6, 3'h2, "open polarity");
      end
    end
    $display("test indicators done");

    @(posedge clk);
    strapLevel <= 3'h2;
    repeat (10) @(posedge clk);
    #1;
    chk_pins(strapCfg, 3'h5, "straps steady in operation");
    @(posedge clk);
    rstPinN <= 1'b0;
    repeat (5) @(posedge clk);
    rstPinN <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk_pins(strapCfg, 3'h2, "straps after pin reset");
    chk_pins(padDrive.oe, 3'h0, "pins released by pin reset");
    rd_chk(`LGP_ADDR_STRAP_STAT, 32'h2, "strap status relatched");
    rd_chk(`LGP_ADDR_IND_CFG, 32'h0, "indicator cfg after pin reset");
    $display("test pin reset done");
    close_out();
  end
endmodule // led_gpio_pin_select_tb_top

`default_nettype wire
